// ==== core/mbcr_match.sv ====
// Per-buffer eligibility logic: cycle filter, slot match and channel selection.
module mbcr_match (
    input  wire logic [15:0] cycle_cfg_i,
    input  wire logic [10:0] slot_id_i,
    input  wire logic [5:0]  cycle_count_i,
    input  wire logic [10:0] cur_slot_i,
    input  wire logic        dynamic_i,
    input  wire logic        rx_valid_a_i,
    input  wire logic        rx_valid_b_i,
    output logic             tx_a_o,
    output logic             tx_b_o,
    output logic             rx_hit_o,
    output logic             rx_from_b_o
);
    logic       ch_a;
    logic       ch_b;
    logic [5:0] msk;
    logic [5:0] val;
    logic       cyc_ok;
    logic       slot_ok;
    logic       take_b;

    // Field extraction and cycle counter filter.
    assign ch_a    = cycle_cfg_i[mbcr_pkg::BIT_CH_A];
    assign ch_b    = cycle_cfg_i[mbcr_pkg::BIT_CH_B];
    assign msk     = cycle_cfg_i[mbcr_pkg::MASK_LSB +: mbcr_pkg::CYCLE_W];
    assign val     = cycle_cfg_i[mbcr_pkg::VALUE_LSB +: mbcr_pkg::CYCLE_W];
    assign cyc_ok  = !cycle_cfg_i[mbcr_pkg::BIT_FILTER_ON]
                     || ((cycle_count_i & msk) == (val & msk));
    assign slot_ok = (slot_id_i == cur_slot_i);

    // Channel B is dropped in the dynamic segment when both channels are assigned.
    assign take_b      = ch_b && !(ch_a && dynamic_i);
    assign tx_a_o      = cyc_ok && slot_ok && ch_a;
    assign tx_b_o      = cyc_ok && slot_ok && take_b;
    // Channel A wins when both deliver a valid frame in the same cycle.
    assign rx_from_b_o = cyc_ok && slot_ok
                         && !(ch_a && rx_valid_a_i) && take_b && rx_valid_b_i;
    assign rx_hit_o    = cyc_ok && slot_ok
                         && ((ch_a && rx_valid_a_i) || (take_b && rx_valid_b_i));
endmodule // mbcr_match

// ==== core/mbcr_regs.sv ====
// Configuration register bank of the individual message buffers with Wishbone slave.
module mbcr_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Protocol engine side, same clock.
    input  wire logic [5:0]  cycle_count_i,
    input  wire logic [10:0] cur_slot_i,
    input  wire logic [1:0]  cur_buf_i,
    input  wire logic        rx_valid_a_i,
    input  wire logic        rx_valid_b_i,
    input  wire logic        xfer_done_i,
    input  wire logic [7:0]  new_index_i,
    // Data field offset that the engine read from bytes six and seven of the header.
    input  wire logic [15:0] header_offset_i,
    output logic             tx_a_o,
    output logic             tx_b_o,
    output logic             tx_repeat_o,
    output logic             rx_store_o,
    output logic             rx_from_b_o,
    output logic      [15:0] header_start_address_o,
    output logic      [15:0] data_start_address_o
);
    logic [15:0] cfg_reg   [mbcr_pkg::NUM_BUF];
    logic [15:0] cfg_next  [mbcr_pkg::NUM_BUF];
    logic [10:0] slot_reg  [mbcr_pkg::NUM_BUF];
    logic [10:0] slot_next [mbcr_pkg::NUM_BUF];
    logic [7:0]  idx_reg   [mbcr_pkg::NUM_BUF];
    logic [7:0]  idx_next  [mbcr_pkg::NUM_BUF];
    logic        dyn_reg;
    logic        dyn_next;
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic        txa_reg;
    logic        txb_reg;
    logic        rpt_reg;
    logic        rxs_reg;
    logic        rxb_reg;
    logic [15:0] hsa_reg;
    logic [15:0] dsa_reg;
    logic [15:0] hsa_next;
    logic [15:0] dsa_next;
    logic [15:0] slot_wide;
    logic        m_txa;
    logic        m_txb;
    logic        m_rx;
    logic        m_rxb;
    logic        wr_en;
    logic [1:0]  sel_buf;
    logic [3:0]  sel_ofs;

    // Merge write data into a 16-bit register honouring the two low byte lanes.
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction

    // Header start address from an index: ten bytes per header above the RAM base.
    function automatic logic [15:0] hdr_addr(input logic [7:0] idx);
        logic [15:0] p;
        p = 16'(16'(idx) * mbcr_pkg::HDR_BYTES);
        return 16'(p + mbcr_pkg::RAM_BASE);
    endfunction

    assign sel_buf = wb_adr_i[5:4];
    assign sel_ofs = wb_adr_i[3:0];
    assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;

    mbcr_match u_match (
        .cycle_cfg_i   (cfg_reg[cur_buf_i]),
        .slot_id_i     (slot_reg[cur_buf_i]),
        .cycle_count_i (cycle_count_i),
        .cur_slot_i    (cur_slot_i),
        .dynamic_i     (dyn_reg),
        .rx_valid_a_i  (rx_valid_a_i),
        .rx_valid_b_i  (rx_valid_b_i),
        .tx_a_o        (m_txa),
        .tx_b_o        (m_txb),
        .rx_hit_o      (m_rx),
        .rx_from_b_o   (m_rxb)
    );

    // Register writes from the host and index updates from the controller.
    always_comb begin
        for (int i = 0; i < mbcr_pkg::NUM_BUF; i++) begin
            cfg_next[i]  = cfg_reg[i];
            slot_next[i] = slot_reg[i];
            idx_next[i]  = idx_reg[i];
        end
        dyn_next = dyn_reg;
        slot_wide = 16'h0000;
        if (wr_en) begin
            case (sel_ofs)
                mbcr_pkg::OFS_CYCLE_CFG: begin
                    cfg_next[sel_buf] = merge16(cfg_reg[sel_buf], wb_dat_i, wb_sel_i);
                end
                mbcr_pkg::OFS_SLOT_ID: begin
                    slot_wide          = merge16({5'h00, slot_reg[sel_buf]}, wb_dat_i, wb_sel_i);
                    slot_next[sel_buf] = slot_wide[10:0];
                end
                mbcr_pkg::OFS_HDR_INDEX: begin
                    if (wb_sel_i[0]) begin
                        idx_next[sel_buf] = wb_dat_i[7:0];
                    end
                end
                mbcr_pkg::OFS_SEGMENT: begin
                    if (wb_sel_i[0]) begin
                        dyn_next = wb_dat_i[0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Controller update wins over a host write in the same cycle.
        if (xfer_done_i) begin
            idx_next[cur_buf_i] = new_index_i;
        end
    end

    // Bus answer: one registered ack a cycle after the request, unmapped offsets read zero.
    always_comb begin
        ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
        rdat_next = 32'h0000_0000;
        case (sel_ofs)
            mbcr_pkg::OFS_CYCLE_CFG: rdat_next = {16'h0000, cfg_reg[sel_buf]};
            mbcr_pkg::OFS_SLOT_ID:   rdat_next = {21'h000000, slot_reg[sel_buf]};
            mbcr_pkg::OFS_HDR_INDEX: rdat_next = {24'h000000, idx_reg[sel_buf]};
            mbcr_pkg::OFS_SEGMENT:   rdat_next = {31'h00000000, dyn_reg};
            default:                 rdat_next = 32'h0000_0000;
        endcase
        hsa_next = hdr_addr(idx_reg[cur_buf_i]);
        dsa_next = 16'(mbcr_pkg::RAM_BASE + header_offset_i);
    end

    // Registers of the bank and the registered engine outputs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < mbcr_pkg::NUM_BUF; i++) begin
                cfg_reg[i]  <= mbcr_pkg::CYCLE_CFG_RESET;
                slot_reg[i] <= mbcr_pkg::SLOT_ID_RESET;
                idx_reg[i]  <= mbcr_pkg::INDEX_RESET;
            end
            dyn_reg  <= 1'b0;
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            txa_reg  <= 1'b0;
            txb_reg  <= 1'b0;
            rpt_reg  <= 1'b0;
            rxs_reg  <= 1'b0;
            rxb_reg  <= 1'b0;
            // Header address of the reset index, so the address never leaves the RAM.
            hsa_reg  <= hdr_addr(mbcr_pkg::INDEX_RESET);
            dsa_reg  <= mbcr_pkg::RAM_BASE;
        end else begin
            for (int i = 0; i < mbcr_pkg::NUM_BUF; i++) begin
                cfg_reg[i]  <= cfg_next[i];
                slot_reg[i] <= slot_next[i];
                idx_reg[i]  <= idx_next[i];
            end
            dyn_reg  <= dyn_next;
            ack_reg  <= ack_next;
            rdat_reg <= rdat_next;
            txa_reg  <= m_txa;
            txb_reg  <= m_txb;
            rpt_reg  <= cfg_reg[cur_buf_i][mbcr_pkg::BIT_TX_REPEAT];
            rxs_reg  <= m_rx;
            rxb_reg  <= m_rxb;
            hsa_reg  <= hsa_next;
            dsa_reg  <= dsa_next;
        end
    end

    assign wb_ack_o               = ack_reg;
    assign wb_dat_o               = rdat_reg;
    assign tx_a_o                 = txa_reg;
    assign tx_b_o                 = txb_reg;
    assign tx_repeat_o            = rpt_reg;
    assign rx_store_o             = rxs_reg;
    assign rx_from_b_o            = rxb_reg;
    assign header_start_address_o = hsa_reg;
    assign data_start_address_o   = dsa_reg;
endmodule // mbcr_regs

// ==== pkg/mbcr_pkg.sv ====
// Package with register map, field layout and constants of the buffer configuration bank.
// Overview of operation
// - Bit 15 picks event (0) or state (1) transmission for transmit buffers.
// - Two channel bits choose channels; both zero means no transmit and no store.
// - Both bits set: static uses both channels, dynamic uses channel A only.
// - One bit set: that channel only, same in static and dynamic segments.
// - Bit 12 switches cycle counter filtering on when set.
// - Mask sits in bits 11 to 6, compare value in bits 5 to 0.
// - Receive buffer is a candidate only when slot identifier equals the frame slot.
// - Transmit buffer sends in the slot named by its slot identifier.
// - Controller rewrites the header index after each reception or transmission.
// - Buffer is control registers plus a physical buffer in message RAM.
// - Header holds frame header, data offset, slot status; offset locates data field.
// - The header field is one contiguous ten-byte region of message RAM.
// - Header bytes: six frame header, two data offset, two slot status.
// - Data field start is the data offset added to base 0x800.
package mbcr_pkg;
    localparam int          NUM_BUF          = 4;
    localparam int          BUF_BITS         = 2;
    localparam int          ADDR_W           = 6;
    // Byte offsets: buffer n occupies a 16-byte block at n*16.
    localparam logic [3:0]  OFS_CYCLE_CFG    = 4'h0;
    localparam logic [3:0]  OFS_SLOT_ID      = 4'h4;
    localparam logic [3:0]  OFS_HDR_INDEX    = 4'h8;
    localparam logic [3:0]  OFS_SEGMENT      = 4'hC;
    // Cycle filter register fields.
    localparam int          BIT_TX_REPEAT    = 15;
    localparam int          BIT_CH_A         = 14;
    localparam int          BIT_CH_B         = 13;
    localparam int          BIT_FILTER_ON    = 12;
    localparam int          MASK_LSB         = 6;
    localparam int          VALUE_LSB        = 0;
    localparam int          CYCLE_W          = 6;
    localparam int          SLOT_W           = 11;
    localparam int          INDEX_W          = 8;
    localparam logic [15:0] CYCLE_CFG_RESET  = 16'h0000;
    localparam logic [10:0] SLOT_ID_RESET    = 11'h000;
    localparam logic [7:0]  INDEX_RESET      = 8'h00;
    // Physical buffer layout in message RAM.
    localparam logic [15:0] RAM_BASE         = 16'h0800;
    localparam logic [15:0] HDR_BYTES        = 16'h000A;
    localparam logic [15:0] HDR_OFS_DATAOFS  = 16'h0006;
    localparam logic [15:0] HDR_OFS_STATUS   = 16'h0008;
endpackage : mbcr_pkg

// ==== test/mbcr_regs_properties.sv ====
// Checker of the buffer configuration bank with its bind statement.
module mbcr_regs_checker (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic [1:0]  cur_buf_i,
    input  wire logic        rx_valid_a_i,
    input  wire logic        rx_valid_b_i,
    input  wire logic        xfer_done_i,
    input  wire logic [7:0]  new_index_i,
    input  wire logic        rx_store_o,
    input  wire logic        rx_from_b_o,
    input  wire logic [15:0] header_start_address_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] exp_hdr_reg;
    logic [15:0] exp_hdr_next;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Header address that a completed transfer should leave behind.
    always_comb begin
        exp_hdr_next = xfer_done_i
                       ? 16'(mbcr_pkg::RAM_BASE + 16'(new_index_i) * mbcr_pkg::HDR_BYTES)
                       : exp_hdr_reg;
    end
    // Registers the expected header address.
    always_ff @(posedge clk_i) begin
        exp_hdr_reg <= exp_hdr_next;
    end
    sequence bus_req_s;
        wb_cyc_i && wb_stb_i;
    endsequence
    sequence index_upd_s;
        xfer_done_i ##1 (!xfer_done_i && $stable(cur_buf_i) && !wb_cyc_i)[*2];
    endsequence
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge lasted more than one cycle.");
    ack_needs_req_a: assert property (wb_ack_o |-> bus_req_s)
        else $error("Acknowledge without a request.");
    ack_bound_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:4] wb_ack_o)
        else $error("Request not acknowledged in time.");
    read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
        else $error("Upper read data not zero.");
    hdr_align_a: assert property (!header_start_address_o[0] && header_start_address_o >= 16'h0800)
        else $error("Header address unaligned or below base.");
    hdr_update_a: assert property (index_upd_s |-> header_start_address_o == exp_hdr_reg)
        else $error("Header address not updated after transfer.");
    store_valid_a: assert property (rx_store_o |-> $past(rx_valid_a_i) || $past(rx_valid_b_i))
        else $error("Frame stored without a valid frame.");
    from_b_valid_a: assert property (rx_store_o && rx_from_b_o |-> $past(rx_valid_b_i))
        else $error("Store from channel B without a valid frame there.");
endmodule // mbcr_regs_checker

bind mbcr_regs mbcr_regs_checker chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_dat_o, .wb_ack_o, .cur_buf_i, .rx_valid_a_i, .rx_valid_b_i, .xfer_done_i,
    .new_index_i, .rx_store_o, .rx_from_b_o, .header_start_address_o);

// ==== test/message_buffer_config_regs_tb.sv ====
// Self-checking testbench of the buffer configuration bank.
module message_buffer_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] cfg; logic [5:0] cyc; logic [10:0] slot;
                    logic va; logic vb; logic dyn; logic [4:0] exp;} mbcr_row_s;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [5:0]  wb_adr = 6'h00, cycle_count = 6'h00;
    logic [31:0] wb_dat = 32'h0000_0000, rd, wb_dat_o;
    logic [10:0] cur_slot = 11'h000;
    logic [1:0]  cur_buf = 2'h0;
    logic        va = 1'b0, vb = 1'b0, xfer_done = 1'b0, wb_ack_o;
    logic [7:0]  new_index = 8'h00;
    logic        tx_a, tx_b, tx_rep, rx_store, rx_from_b;
    logic [15:0] hdr_addr, data_addr, hdr_ofs = 16'h0040;
    int          n_mismatch = 0, samples_checked = 0, cycles = 0;
    // Rows give configuration, cycle, slot, valids, dynamic segment and
    // {tx_a, tx_b, repeat, store, from_b}.
    mbcr_row_s rows [12] = '{
        '{16'h4000, 6'h00, 11'h005, 1'b1, 1'b0, 1'b0, 5'b10010},
        '{16'h2000, 6'h00, 11'h005, 1'b0, 1'b1, 1'b0, 5'b01011},
        '{16'h0000, 6'h00, 11'h005, 1'b1, 1'b1, 1'b0, 5'b00000},
        '{16'hC000, 6'h00, 11'h005, 1'b0, 1'b1, 1'b0, 5'b10100},
        '{16'h5FC5, 6'h05, 11'h005, 1'b1, 1'b0, 1'b0, 5'b10010},
        '{16'h5FC5, 6'h06, 11'h005, 1'b1, 1'b0, 1'b0, 5'b00000},
        '{16'h5041, 6'h03, 11'h005, 1'b1, 1'b0, 1'b0, 5'b10010},
        '{16'h4000, 6'h00, 11'h006, 1'b1, 1'b0, 1'b0, 5'b00000},
        '{16'h6000, 6'h00, 11'h005, 1'b0, 1'b1, 1'b0, 5'b11011},
        '{16'h6000, 6'h00, 11'h005, 1'b1, 1'b1, 1'b0, 5'b11010},
        '{16'h6000, 6'h00, 11'h005, 1'b0, 1'b1, 1'b1, 5'b10000},
        '{16'h2000, 6'h00, 11'h005, 1'b0, 1'b1, 1'b1, 5'b01011}};
    mbcr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cycle_count_i(cycle_count),
        .cur_slot_i(cur_slot), .cur_buf_i(cur_buf), .rx_valid_a_i(va), .rx_valid_b_i(vb),
        .xfer_done_i(xfer_done), .new_index_i(new_index), .header_offset_i(hdr_ofs),
        .tx_a_o(tx_a), .tx_b_o(tx_b),
        .tx_repeat_o(tx_rep), .rx_store_o(rx_store), .rx_from_b_o(rx_from_b),
        .header_start_address_o(hdr_addr), .data_start_address_o(data_addr));
    // Clock of 4 ns period.
    always #2 clk_i = ~clk_i;
    // Cuts a hang short.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // Compares one value and counts the result.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One classic bus cycle; ack and read data are taken at the rising edge that sees ack.
    task automatic wb(input logic we, input logic [5:0] adr, input logic [15:0] wd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= {16'h0000, wd};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        rd = wb_dat_o;
        if (n >= 20) chk(32'h0, 32'h1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk_i);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Main sequence: reset, table of cases, then index handling.
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 6'h00, 16'h0);
        chk(rd, {16'h0, mbcr_pkg::CYCLE_CFG_RESET});
        wb(1'b0, 6'h04, 16'h0);
        chk(rd, {21'h0, mbcr_pkg::SLOT_ID_RESET});
        chk({16'h0, hdr_addr}, {16'h0, mbcr_pkg::RAM_BASE});
        chk({16'h0, data_addr}, 32'h0000_0840);
        wb(1'b1, 6'h04, 16'h0005);
        foreach (rows[i]) begin
            wb(1'b1, 6'h0C, {15'h0000, rows[i].dyn});
            wb(1'b1, 6'h00, rows[i].cfg);
            cycle_count <= rows[i].cyc;
            cur_slot <= rows[i].slot;
            va <= rows[i].va;
            vb <= rows[i].vb;
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            chk({27'h0, tx_a, tx_b, tx_rep, rx_store, rx_from_b},
                {27'h0, rows[i].exp});
            @(posedge clk_i);
        end
        wb(1'b1, 6'h14, 16'hFFFF);
        wb(1'b0, 6'h14, 16'h0);
        chk(rd, 32'h0000_07FF);
        cur_buf <= 2'h2;
        wb(1'b1, 6'h28, 16'h0012);
        wb(1'b0, 6'h28, 16'h0);
        chk(rd, 32'h0000_0012);
        chk({16'h0, hdr_addr}, 32'h0000_08B4);
        new_index <= 8'h33;
        xfer_done <= 1'b1;
        @(posedge clk_i);
        xfer_done <= 1'b0;
        repeat (3) @(posedge clk_i);
        wb(1'b0, 6'h28, 16'h0);
        chk(rd, 32'h0000_0033);
        chk({16'h0, hdr_addr}, 32'h0000_09FE);
        // A second reset in mid-run returns the index and header address to reset values.
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 6'h28, 16'h0);
        chk(rd, {24'h0, mbcr_pkg::INDEX_RESET});
        chk({16'h0, hdr_addr}, {16'h0, mbcr_pkg::RAM_BASE});
        finish_test();
    end
endmodule // message_buffer_config_regs_tb
